// *** design/adc_sequence_result_control.v ***
// Sequence length, result placement, justification and freeze control of the converter
//
// Contract
// - Any control-three write aborts running sequence
// - Justify bit: 0 left, 1 right
// - Stored results always unsigned
// - Four-bit length field, resets to four
// - Non-FIFO: nth result to nth register
// - FIFO: counter kept across sequence boundaries
// - FIFO scan wraps to first register
// - Counter readable in four-bit status field
// - Abort or start clears counter always
// - Complete flags mark valid result registers
// - FIFO mode disables automatic compare
// - Two-bit field selects breakpoint freeze response
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctl3_defs.vh"

module adc_sequence_result_control (
   input  wire        ref_clk_i,        // Bus clock
   input  wire        reset_n_i,        // Async reset, active low
   input  wire [3:0]  address_i,        // Avalon word address
   input  wire        read_i,           // Avalon read
   input  wire        write_i,          // Avalon write
   input  wire [31:0] writedata_i,      // Avalon write data
   input  wire [3:0]  byteenable_i,     // Avalon byte enables
   output reg  [31:0] readdata_o,       // Avalon read data
   output wire        waitrequest_o,    // Avalon wait
   input  wire        freeze_i,         // Debug breakpoint freeze
   input  wire        conv_done_i,      // Analog conversion finished
   input  wire [9:0]  conv_data_i,      // Raw unsigned conversion
   input  wire        compare_hit_i,    // Compare condition from channel
   input  wire        compare_ie_i,     // Compare interrupt enable
   input  wire [15:0] channel_cmp_en_i, // Per-channel compare enables
   output wire        conv_start_o,     // Request analog conversion
   output wire        compare_active_o, // Automatic compare allowed
   output wire [15:0] channel_cmp_o,    // Effective per-channel enables
   output wire        irq_o             // Level interrupt
);

   // ===========================================================
   // State
   // ===========================================================
   localparam ST_IDLE  = 2'h0;
   localparam ST_CONV  = 2'h1;
   localparam ST_WAIT  = 2'h2;

   reg  [7:0]  ctl_three;
   reg  [7:0]  ctl_five;
   reg  [1:0]  state;
   reg  [1:0]  next_state;
   reg  [3:0]  conv_count;
   reg  [4:0]  seq_done;
   reg  [15:0] complete_flags;
   reg  [15:0] result_file [0:15];
   reg  [1:0]  irq_status;
   reg  [1:0]  irq_mask;
   reg         ack;
   reg         frozen_pending;
   integer     i;

   wire fifo_mode  = ctl_three[`FIFO_BIT];
   wire [1:0] frz  = ctl_three[`FREEZE_HI:`FREEZE_LO];
   wire scan_mode  = ctl_five[5];
   wire wr_hit     = write_i & ~ack;
   wire wr_three   = wr_hit & (address_i == `OFF_CTL_THREE) & byteenable_i[0];
   wire wr_five    = wr_hit & (address_i == `OFF_CTL_FIVE) & byteenable_i[0];
   wire wr_irq     = wr_hit & (address_i == `OFF_IRQ_STATUS) & byteenable_i[0];
   wire wr_mask    = wr_hit & (address_i == `OFF_IRQ_MASK) & byteenable_i[0];

   // Zero length means the full result file
   function [4:0] seq_len;
      input [3:0] f;
      begin
         seq_len = (f == 4'h0) ? `MAX_SEQ_LEN : {1'b0, f};
      end
   endfunction

   // Unsigned result, left or right justified in a 16-bit word
   function [15:0] justify;
      input [9:0] d;
      input       right;
      begin
         justify = right ? {6'h00, d} : {d, 6'h00};
      end
   endfunction

   // ===========================================================
   // Freeze handling
   // ===========================================================
   wire hold_now    = freeze_i & (frz == `FRZ_NOW);
   wire hold_finish = freeze_i & (frz == `FRZ_FINISH);
   wire store_conv  = (state == ST_CONV) & conv_done_i & ~hold_now & ~frozen_pending
                      & ~wr_three & ~wr_five;
   wire seq_last    = (seq_done + 5'h01) >= seq_len(ctl_three[`SEQ_LEN_HI:`SEQ_LEN_LO]);
   wire set_done    = store_conv & seq_last;
   wire set_abort   = wr_three & (state != ST_IDLE);

   assign conv_start_o     = (state == ST_CONV) & ~hold_now & ~frozen_pending;
   assign compare_active_o = compare_ie_i & ~fifo_mode;
   assign channel_cmp_o    = fifo_mode ? 16'h0000 : channel_cmp_en_i;
   assign waitrequest_o    = (read_i | write_i) & ~ack;
   assign irq_o            = |(irq_status & irq_mask);

   // ===========================================================
   // Control registers
   // ===========================================================
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctl_three <= `CTL_THREE_RESET;
         ctl_five  <= 8'h00;
         irq_mask  <= 2'h0;
      end else begin
         if (wr_three)
            ctl_three <= writedata_i[7:0];
         if (wr_five)
            ctl_five <= writedata_i[7:0];
         if (wr_mask)
            irq_mask <= writedata_i[1:0];
      end
   end

   // ===========================================================
   // Sequencer
   // ===========================================================
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            next_state = ST_IDLE;
         end
         ST_CONV: begin
            if (set_done && !scan_mode)
               next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (wr_three)
         next_state = ST_IDLE;
      else if (wr_five)
         next_state = ST_CONV;
   end

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state          <= ST_IDLE;
         conv_count     <= 4'h0;
         seq_done       <= 5'h00;
         frozen_pending <= 1'b0;
      end else begin
         state <= next_state;
         // Finish mode: hold after the running conversion lands
         frozen_pending <= hold_finish & (frozen_pending | store_conv);
         if (wr_three || wr_five) begin
            conv_count <= 4'h0;
            seq_done   <= 5'h00;
         end else if (store_conv) begin
            conv_count <= conv_count + 4'h1;
            if (seq_last) begin
               seq_done <= 5'h00;
               if (!fifo_mode)
                  conv_count <= 4'h0;
            end else begin
               seq_done <= seq_done + 5'h01;
            end
         end
      end
   end

   // ===========================================================
   // Result storage
   // ===========================================================
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         complete_flags <= 16'h0000;
         for (i = 0; i < 16; i = i + 1)
            result_file[i] <= 16'h0000;
      end else begin
         if (wr_five) begin
            complete_flags <= 16'h0000;
         end else if (store_conv) begin
            result_file[conv_count] <= justify(conv_data_i, ctl_three[`JUSTIFY_BIT]);
            complete_flags[conv_count] <= 1'b1;
         end
      end
   end

   // ===========================================================
   // Interrupt status
   // ===========================================================
   // Clear by writing one; a same-cycle event wins
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_status <= 2'h0;
      end else begin
         irq_status[`IRQ_SEQ_DONE] <= set_done |
            (irq_status[`IRQ_SEQ_DONE] & ~(wr_irq & writedata_i[`IRQ_SEQ_DONE]));
         irq_status[`IRQ_ABORT] <= set_abort |
            (irq_status[`IRQ_ABORT] & ~(wr_irq & writedata_i[`IRQ_ABORT]));
      end
   end

   // ===========================================================
   // Avalon slave
   // ===========================================================
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ack        <= 1'b0;
         readdata_o <= 32'h00000000;
      end else begin
         ack <= (read_i | write_i) & ~ack;
         if (read_i & ~ack) begin
            case (address_i)
               `OFF_CTL_THREE:   readdata_o <= {24'h000000, ctl_three};
               `OFF_CTL_FIVE:    readdata_o <= {24'h000000, ctl_five};
               `OFF_STATUS_ZERO: readdata_o <= {28'h0000000, conv_count};
               `OFF_COMPLETE_FLAGS: readdata_o <= {16'h0000, complete_flags};
               `OFF_IRQ_STATUS:  readdata_o <= {30'h00000000, irq_status};
               `OFF_IRQ_MASK:    readdata_o <= {30'h00000000, irq_mask};
               `OFF_RESULT_ZERO: readdata_o <= {16'h0000, result_file[0]};
               default:          readdata_o <= 32'h00000000;
            endcase
         end
      end
   end

endmodule // adc_sequence_result_control
`default_nettype wire

// *** design/adc_ctl3_defs.vh ***
// Constants for the converter sequence and result control block
`ifndef ADC_CTL3_DEFS_VH
`define ADC_CTL3_DEFS_VH
// Register word offsets on the Avalon word address
`define OFF_CTL_THREE      4'h3
`define OFF_CTL_FIVE       4'h5
`define OFF_STATUS_ZERO    4'h6
`define OFF_IRQ_STATUS     4'h8
`define OFF_IRQ_MASK       4'h9
`define OFF_COMPLETE_FLAGS 4'h7
`define OFF_RESULT_ZERO    4'ha
`define OFF_RESULT_BASE    4'h0
// Control three fields
`define JUSTIFY_BIT        7
`define SEQ_LEN_HI         6
`define SEQ_LEN_LO         3
`define FIFO_BIT           2
`define FREEZE_HI          1
`define FREEZE_LO          0
`define CTL_THREE_RESET    8'h20
// Freeze encodings
`define FRZ_CONTINUE       2'h0
`define FRZ_RESERVED       2'h1
`define FRZ_FINISH         2'h2
`define FRZ_NOW            2'h3
// Result file and conversion timing
`define RESULT_COUNT       5'h10
`define MAX_SEQ_LEN        5'h10
`define CONV_TIME_NS       1000
`define CLK_PERIOD_NS      100
`define CONV_CYCLES        ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Interrupt status bits
`define IRQ_SEQ_DONE       0
`define IRQ_ABORT          1
`endif

// *** test/adc_seq_chk.sv ***
// Assertions on the ports of the sequence and result control block
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctl3_defs.vh"
module adc_seq_chk (
   input wire logic        ref_clk_i,        // Clock
   input wire logic        reset_n_i,        // Reset
   input wire logic [3:0]  address_i,        // Address
   input wire logic        read_i,           // Read
   input wire logic        write_i,          // Write
   input wire logic [31:0] readdata_o,       // Read data
   input wire logic        waitrequest_o,    // Wait
   input wire logic        freeze_i,         // Freeze
   input wire logic        compare_ie_i,     // Compare enable
   input wire logic [15:0] channel_cmp_en_i, // Channel enables
   input wire logic        conv_start_o,     // Running
   input wire logic        compare_active_o, // Compare allowed
   input wire logic [15:0] channel_cmp_o     // Effective enables
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   AST_WAIT_HI: assert property ($rose(read_i | write_i) |-> waitrequest_o)
      else $error("Missing wait state");
   AST_WAIT_ONE: assert property ((read_i | write_i) && waitrequest_o |=> !waitrequest_o)
      else $error("Wait longer than one cycle");
   AST_NO_WAIT: assert property (!(read_i | write_i) |-> !waitrequest_o)
      else $error("Wait without request");
   AST_ABORT: assert property (
      write_i && !waitrequest_o && address_i == `OFF_CTL_THREE |=> !conv_start_o)
      else $error("Sequence not aborted");
   AST_START: assert property (
      write_i && !waitrequest_o && address_i == `OFF_CTL_FIVE && !freeze_i
      |-> ##[1:3] conv_start_o) else $error("Sequence not started");
   AST_CMP_MASK: assert property ((channel_cmp_o & ~channel_cmp_en_i) == 16'h0000)
      else $error("Channel compare not masked");
   AST_CMP_PASS: assert property (
      compare_active_o |-> compare_ie_i && channel_cmp_o == channel_cmp_en_i)
      else $error("Compare enables not passed");
   AST_CMP_OFF: assert property (
      compare_ie_i && !compare_active_o |-> channel_cmp_o == 16'h0000)
      else $error("Channel compare left on");
   AST_RD_HOLD: assert property (!read_i |=> $stable(readdata_o))
      else $error("Read data changed");
   cover property (conv_start_o ##1 !conv_start_o);
   cover property (compare_ie_i && !compare_active_o);
   cover property (write_i && !waitrequest_o && address_i == `OFF_CTL_THREE);
endmodule // adc_seq_chk
`default_nettype wire

// *** test/adc_sequence_result_control_tb.sv ***
// Self-checking bench for the sequence and result control block
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctl3_defs.vh"
module adc_sequence_result_control_tb;
   logic        clk = 0, rst_n = 0, rd = 0, wr = 0, done = 0, frz = 0, cie = 0;
   logic [3:0]  adr = 0;
   logic [31:0] wd = 0, rdat;
   logic [9:0]  cd = 0;
   logic [15:0] cen = 0;
   wire  [31:0] rdo;
   wire  [15:0] cco;
   wire         wq, cs, ca, irq;
   int          mismatches = 0, n_compared = 0, n;
   always #50 clk = ~clk;
   adc_sequence_result_control uut (.ref_clk_i(clk), .reset_n_i(rst_n), .address_i(adr),
      .read_i(rd), .write_i(wr), .writedata_i(wd), .byteenable_i(4'hf), .readdata_o(rdo),
      .waitrequest_o(wq), .freeze_i(frz), .conv_done_i(done), .conv_data_i(cd),
      .compare_hit_i(1'b0), .compare_ie_i(cie), .channel_cmp_en_i(cen), .conv_start_o(cs),
      .compare_active_o(ca), .channel_cmp_o(cco), .irq_o(irq));
   task automatic final_report;
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One bus access, held until wait drops
   task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      rd <= !w; wr <= w; adr <= a; wd <= d;
      n = 0;
      do begin @(posedge clk); n++; end while (wq && n < 20);
      if (wq) begin mismatches++; final_report(); end
      rdat = rdo;
      rd <= 0; wr <= 0;
      @(posedge clk);
   endtask
   task automatic cv(input logic [9:0] d);
      cd <= d; done <= 1;
      @(posedge clk);
      done <= 0;
      @(posedge clk);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      acc(0, `OFF_CTL_THREE, 0); chk(rdat, 32'h20);
      acc(1, 4'hf, 32'hff); acc(0, 4'hf, 0); chk(rdat, 32'h0);
      acc(1, `OFF_IRQ_MASK, 32'h3);
      acc(1, `OFF_CTL_THREE, 32'ha0); acc(0, `OFF_CTL_THREE, 0); chk(rdat, 32'ha0);
      $display("Registers test done");
      cie <= 1; cen <= 16'ha5a5;
      acc(1, `OFF_CTL_FIVE, 32'h0);
      cv(10'h2c5);
      acc(0, `OFF_STATUS_ZERO, 0); chk(rdat[3:0], 4'h1);
      acc(0, 4'h7, 0); chk(rdat[0], 1'b1);
      acc(0, `OFF_RESULT_ZERO, 0); chk(rdat, 32'h2c5);
      chk(ca, 1'b1); chk(cco, 16'ha5a5);
      repeat (3) cv(10'h155);
      @(negedge clk); chk(cs, 1'b0); chk(irq, 1'b1);
      acc(0, `OFF_IRQ_STATUS, 0); chk(rdat[0], 1'b1);
      acc(1, `OFF_IRQ_STATUS, 32'h3); @(negedge clk); chk(irq, 1'b0);
      $display("Sequence test done");
      acc(1, `OFF_CTL_THREE, 32'h0c); @(negedge clk); chk(ca, 1'b0); chk(cco, 16'h0);
      acc(1, `OFF_CTL_FIVE, 32'h20);
      for (int i = 0; i < 17; i++) cv(i[9:0]);
      acc(0, `OFF_STATUS_ZERO, 0); chk(rdat[3:0], 4'h1);
      acc(1, `OFF_CTL_FIVE, 32'h20); acc(0, `OFF_STATUS_ZERO, 0); chk(rdat[3:0], 4'h0);
      @(negedge clk); chk(cs, 1'b1);
      acc(1, `OFF_CTL_THREE, 32'h0c); @(negedge clk); chk(cs, 1'b0);
      acc(0, `OFF_IRQ_STATUS, 0); chk(rdat[1], 1'b1);
      $display("FIFO and abort test done");
      acc(1, `OFF_CTL_THREE, 32'h23); acc(1, `OFF_CTL_FIVE, 32'h0);
      frz <= 1; @(negedge clk); chk(cs, 1'b0);
      acc(1, `OFF_CTL_THREE, 32'h20); acc(1, `OFF_CTL_FIVE, 32'h0);
      @(negedge clk); chk(cs, 1'b1);
      cv(10'h2c5); acc(0, `OFF_RESULT_ZERO, 0); chk(rdat, 32'hb140);
      acc(1, `OFF_CTL_THREE, 32'h20); frz <= 0;
      acc(1, `OFF_IRQ_MASK, 32'h0); @(negedge clk); chk(irq, 1'b0);
      acc(1, `OFF_IRQ_MASK, 32'h3); @(negedge clk); chk(irq, 1'b1);
      $display("Freeze and interrupt test done");
      final_report();
   end
endmodule // adc_sequence_result_control_tb
bind adc_sequence_result_control adc_seq_chk chk_i (.ref_clk_i, .reset_n_i, .address_i,
   .read_i, .write_i, .readdata_o, .waitrequest_o, .freeze_i, .compare_ie_i,
   .channel_cmp_en_i, .conv_start_o, .compare_active_o, .channel_cmp_o);
`default_nettype wire
